// ===== shared/dcec_pkg.sv
package dcec_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CRC_CTRL_OFS = 8'h00;
  localparam logic [7:0] EVT_CTRL_OFS = 8'h04;
  localparam logic [7:0] INT_STAT_OFS = 8'h08;
  localparam logic [7:0] INT_CLR_OFS  = 8'h0C;
  localparam logic [7:0] INT_EN_OFS   = 8'h10;
  localparam logic [7:0] CHAN_OFS     = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BYTE_ORDER_LSB   = 28;
  localparam int WR_ORDER_BIT     = 27;
  localparam int REFLECT_BIT      = 24;
  localparam int POLY_LEN_LSB     = 8;
  localparam int ROUTE_EN_BIT     = 7;
  localparam int APP_BIT          = 6;
  localparam int TYP_BIT          = 5;
  localparam int AIRQ_LSB         = 16;
  localparam int SIRQ_LSB         = 8;
  localparam int FORCE_BIT        = 7;
  localparam int SWAB_BIT         = 6;
  localparam int PAT_ABORT_BIT    = 5;
  localparam int START_IRQ_EN_BIT = 4;
  localparam int ABORT_IRQ_EN_BIT = 3;
  localparam int CHAN_EN_BIT      = 0;
  localparam int BUSY_BIT         = 1;
  localparam int INT_START        = 0;
  localparam int INT_ABORT        = 1;
  localparam int INT_PAT          = 2;
  localparam int INT_W            = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQ_NUM_RST = 8'hFF;
  localparam logic [4:0] POLY_LEN_RST = 5'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DCEC_BO_NONE, DCEC_BO_WORD, DCEC_BO_HALF, DCEC_BO_HBYTE
  } dcec_byte_order_e;

  typedef struct packed {
    dcec_byte_order_e crc_byte_order;
    logic             write_byte_order;
    logic             crc_bit_reflect;
    logic [4:0]       poly_length_minus_one;
    logic             checksum_route_enable;
    logic             checksum_append;
    logic             checksum_type;
  } dcec_crc_cfg_s;

  typedef struct packed {
    logic [7:0] abort_irq_number;
    logic [7:0] start_irq_number;
    logic       pattern_abort_enable;
    logic       start_on_irq_enable;
    logic       abort_on_irq_enable;
  } dcec_evt_cfg_s;

  typedef struct packed {
    logic [31:0] data;
    logic        valid;
  } dcec_word_s;

endpackage

// ===== verilog/dcec_byte_swap.sv
`timescale 1ns/1ps
`default_nettype none
module dcec_byte_swap
  import dcec_pkg::*;
(
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Configuration.
  input  wire dcec_crc_cfg_s    cfg,
  // Source word and reordered results.
  input  wire dcec_word_s       src,
  output var  dcec_word_s       crc_word,
  output var  dcec_word_s       dst_word
);

  typedef struct packed {
    dcec_word_s crc;
    dcec_word_s dst;
  } dcec_swap_s;

  dcec_swap_s s_reg;
  dcec_swap_s s_next;

  function automatic logic [31:0] reorder(input logic [31:0] d,
                                          input dcec_byte_order_e o);
    unique case (o)
      DCEC_BO_NONE:  reorder = d;
      DCEC_BO_WORD:  reorder = {d[7:0], d[15:8], d[23:16], d[31:24]};
      DCEC_BO_HALF:  reorder = {d[15:0], d[31:16]};
      DCEC_BO_HBYTE: reorder = {d[23:16], d[31:24], d[7:0], d[15:8]};
    endcase
  endfunction

  always_comb begin
    logic [31:0] sw;
    sw = reorder(src.data, cfg.crc_byte_order);
    s_next.crc.data  = sw;
    s_next.crc.valid = src.valid & cfg.checksum_route_enable;
    s_next.dst.data  = cfg.write_byte_order ? sw : src.data;
    s_next.dst.valid = src.valid;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign crc_word = s_reg.crc;
  assign dst_word = s_reg.dst;

  plain_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg.write_byte_order |=> dst_word.data == $past(src.data))
    else $error("Destination data altered with reordering off.");
  word_swap_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.crc_byte_order == DCEC_BO_WORD |=>
    crc_word.data[7:0] == $past(src.data[31:24]))
    else $error("Word byte reversal wrong.");

endmodule
`default_nettype wire

// ===== verilog/dcec_irq_select.sv
`timescale 1ns/1ps
`default_nettype none
module dcec_irq_select
  import dcec_pkg::*;
(
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Interrupt lines and selection.
  input  wire logic [255:0]     irq_lines,
  input  wire logic [7:0]       number,
  input  wire logic             enable,
  // Registered trigger.
  output var  logic             hit
);

  typedef struct packed {
    logic hit;
  } dcec_sel_s;

  dcec_sel_s s_reg;
  dcec_sel_s s_next;

  always_comb begin
    s_next.hit = enable & irq_lines[number];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hit = s_reg.hit;

  ignored_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    !enable |=> !hit)
    else $error("Disabled interrupt selection produced a trigger.");

endmodule
`default_nettype wire

// ===== verilog/dcec_top.sv
//
// Function
// - Byte order field picks none, word reverse, half swap or half reverse.
// - Write byte order set sends reordered data to destination, else raw.
// - With write byte order set, append bit cannot be set; no unaligned use.
// - IP header mode checksum goes LSb first when bit reflect is set.
// - LFSR mode CRC is reflected when bit reflect set, else MSb first.
// - Polynomial length field holds length minus one; ignored in IP mode.
// - Route enable sends channel transfers through the CRC unit.
// - Abort IRQ number selects one of 256 interrupts; abort sets flag.
// - Start IRQ number n selects interrupt n as start source.
// - Writing force bit starts a transfer at once if channel enable is set; reads back zero.
// - Writing software abort bit aborts the transfer; reads back zero.
// - Pattern match with enable aborts and clears channel enable.
// - Start on IRQ enable lets the matching interrupt start one cell.
// - Abort on IRQ enable lets the matching interrupt abort transfer.
// - Unimplemented CRC control bits ignore writes and read zero.
//
`timescale 1ns/1ps
`default_nettype none
module dcec_top
  import dcec_pkg::*;
(
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave.
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output var  logic [31:0]      prdata,
  output var  logic             pready,
  output var  logic             pslverr,
  // Event sources.
  input  wire logic [255:0]     irq_lines,
  input  wire logic             pattern_match,
  input  wire logic             cell_done,
  // Channel control.
  output var  logic             cell_start,
  output var  logic             xfer_abort,
  output var  logic             channel_busy,
  output var  logic             channel_enable,
  output var  logic             irq,
  // CRC configuration and data path.
  output var  dcec_crc_cfg_s    crc_cfg,
  input  wire dcec_word_s       src_word,
  output var  dcec_word_s       crc_word,
  output var  dcec_word_s       dst_word
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic {DCEC_IDLE, DCEC_RUN} dcec_fsm_e;

  typedef struct packed {
    dcec_crc_cfg_s    crc;
    dcec_crc_cfg_s    cfg_out;
    dcec_evt_cfg_s    evt;
    dcec_fsm_e        fsm;
    logic             chan_en;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_en;
    logic             irq;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             cell_start;
    logic             xfer_abort;
  } dcec_state_s;

  localparam dcec_evt_cfg_s EVT_RST = '{
    abort_irq_number: IRQ_NUM_RST, start_irq_number: IRQ_NUM_RST,
    default: 1'b0};

  dcec_state_s s_reg;
  dcec_state_s s_next;
  logic        start_hit;
  logic        abort_hit;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  dcec_irq_select u_start_sel (
    .pclk      (pclk),
    .presetn   (presetn),
    .irq_lines (irq_lines),
    .number    (s_reg.evt.start_irq_number),
    .enable    (s_reg.evt.start_on_irq_enable),
    .hit       (start_hit)
  );

  dcec_irq_select u_abort_sel (
    .pclk      (pclk),
    .presetn   (presetn),
    .irq_lines (irq_lines),
    .number    (s_reg.evt.abort_irq_number),
    .enable    (s_reg.evt.abort_on_irq_enable),
    .hit       (abort_hit)
  );

  dcec_byte_swap u_swap (
    .pclk     (pclk),
    .presetn  (presetn),
    .cfg      (s_reg.crc),
    .src      (src_word),
    .crc_word (crc_word),
    .dst_word (dst_word)
  );

  // ----------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------
  function automatic logic [31:0] crc_word_of(input dcec_crc_cfg_s c);
    logic [31:0] w;
    w = '0;
    w[BYTE_ORDER_LSB+:2] = c.crc_byte_order;
    w[WR_ORDER_BIT]      = c.write_byte_order;
    w[REFLECT_BIT]       = c.crc_bit_reflect;
    w[POLY_LEN_LSB+:5]   = c.poly_length_minus_one;
    w[ROUTE_EN_BIT]      = c.checksum_route_enable;
    w[APP_BIT]      = c.checksum_append;
    w[TYP_BIT]      = c.checksum_type;
    return w;
  endfunction

  function automatic logic [31:0] evt_word_of(input dcec_evt_cfg_s e);
    logic [31:0] w;
    w = '0;
    w[AIRQ_LSB+:8]  = e.abort_irq_number;
    w[SIRQ_LSB+:8]  = e.start_irq_number;
    w[PAT_ABORT_BIT]    = e.pattern_abort_enable;
    w[START_IRQ_EN_BIT] = e.start_on_irq_enable;
    w[ABORT_IRQ_EN_BIT] = e.abort_on_irq_enable;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic setup;
    logic wr;
    logic force_req;
    logic swab_req;
    logic pat_req;
    logic abort_req;
    logic start_req;
    setup     = psel & ~penable;
    wr        = psel & penable & s_reg.pready & pwrite;
    force_req = wr & (paddr == EVT_CTRL_OFS) & pwdata[FORCE_BIT];
    swab_req  = wr & (paddr == EVT_CTRL_OFS) & pwdata[SWAB_BIT];
    pat_req   = pattern_match & s_reg.evt.pattern_abort_enable;
    abort_req = swab_req | abort_hit | pat_req;
    start_req = (force_req | start_hit) & s_reg.chan_en;
    s_next            = s_reg;
    s_next.pready     = 1'b0;
    s_next.pslverr    = 1'b0;
    s_next.cell_start = 1'b0;
    s_next.xfer_abort = 1'b0;
    if (setup) begin
      s_next.pready = 1'b1;
      s_next.prdata = '0;
      unique case (paddr)
        CRC_CTRL_OFS: s_next.prdata = crc_word_of(s_reg.crc);
        EVT_CTRL_OFS: s_next.prdata = evt_word_of(s_reg.evt);
        INT_STAT_OFS: s_next.prdata[INT_W-1:0] = s_reg.int_stat;
        INT_CLR_OFS:  s_next.prdata = '0;
        INT_EN_OFS:   s_next.prdata[INT_W-1:0] = s_reg.int_en;
        CHAN_OFS: begin
          s_next.prdata[CHAN_EN_BIT] = s_reg.chan_en;
          s_next.prdata[BUSY_BIT] = (s_reg.fsm == DCEC_RUN);
        end
        default: s_next.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        CRC_CTRL_OFS: begin
          s_next.crc.crc_byte_order =
            dcec_byte_order_e'(pwdata[BYTE_ORDER_LSB+:2]);
          s_next.crc.write_byte_order      = pwdata[WR_ORDER_BIT];
          s_next.crc.crc_bit_reflect       = pwdata[REFLECT_BIT];
          s_next.crc.poly_length_minus_one = pwdata[POLY_LEN_LSB+:5];
          s_next.crc.checksum_route_enable = pwdata[ROUTE_EN_BIT];
          s_next.crc.checksum_type         = pwdata[TYP_BIT];
          s_next.crc.checksum_append =
            pwdata[APP_BIT] & ~pwdata[WR_ORDER_BIT];
        end
        EVT_CTRL_OFS: begin
          s_next.evt.abort_irq_number     = pwdata[AIRQ_LSB+:8];
          s_next.evt.start_irq_number     = pwdata[SIRQ_LSB+:8];
          s_next.evt.pattern_abort_enable = pwdata[PAT_ABORT_BIT];
          s_next.evt.start_on_irq_enable  = pwdata[START_IRQ_EN_BIT];
          s_next.evt.abort_on_irq_enable  = pwdata[ABORT_IRQ_EN_BIT];
        end
        INT_CLR_OFS: s_next.int_stat = s_reg.int_stat & ~pwdata[INT_W-1:0];
        INT_EN_OFS:  s_next.int_en   = pwdata[INT_W-1:0];
        CHAN_OFS:    s_next.chan_en  = pwdata[CHAN_EN_BIT];
        default: ;
      endcase
    end
    if (abort_req) begin
      s_next.fsm                 = DCEC_IDLE;
      s_next.xfer_abort          = 1'b1;
      s_next.int_stat[INT_ABORT] = 1'b1;
    end else if (start_req) begin
      s_next.fsm                 = DCEC_RUN;
      s_next.cell_start          = 1'b1;
      s_next.int_stat[INT_START] = 1'b1;
    end else if (cell_done) begin
      s_next.fsm = DCEC_IDLE;
    end
    if (pat_req) begin
      s_next.chan_en           = 1'b0;
      s_next.int_stat[INT_PAT] = 1'b1;
    end
    s_next.cfg_out = s_next.crc;
    s_next.cfg_out.crc_bit_reflect = s_next.crc.crc_bit_reflect;
    if (s_next.crc.checksum_type) begin
      s_next.cfg_out.poly_length_minus_one = POLY_LEN_RST;
    end
    s_next.irq = |(s_next.int_stat & s_next.int_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg     <= '0;
      s_reg.evt <= EVT_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata         = s_reg.prdata;
  assign pready         = s_reg.pready;
  assign pslverr        = s_reg.pslverr;
  assign cell_start     = s_reg.cell_start;
  assign xfer_abort     = s_reg.xfer_abort;
  assign channel_busy   = (s_reg.fsm == DCEC_RUN);
  assign channel_enable = s_reg.chan_en;
  assign irq            = s_reg.irq;
  assign crc_cfg        = s_reg.cfg_out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking dcec_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  abort_wins_a: assert property (
    start_hit && abort_hit && s_reg.chan_en |=> xfer_abort && !cell_start)
    else $error("Start beat abort in the same cycle.");
  start_irq_a: assert property (
    start_hit && s_reg.chan_en && !abort_hit && !pattern_match
    && !(psel && penable && pwrite)
    |=> cell_start && channel_busy && s_reg.int_stat[INT_START])
    else $error("Matching start interrupt did not start a cell.");
  abort_irq_a: assert property (
    abort_hit |-> $past(s_reg.evt.abort_on_irq_enable))
    else $error("Abort interrupt acted while disabled.");
  abort_flag_a: assert property (
    abort_hit |=> xfer_abort && s_reg.int_stat[INT_ABORT])
    else $error("Abort did not set the abort flag.");
  pattern_clear_a: assert property (
    pattern_match && s_reg.evt.pattern_abort_enable
    |=> !channel_enable && xfer_abort)
    else $error("Pattern abort did not clear channel enable.");
  pulse_bits_zero_a: assert property (
    pready && paddr == EVT_CTRL_OFS |-> prdata[FORCE_BIT:SWAB_BIT] == 2'h0)
    else $error("Force or abort bit read back nonzero.");
  reserved_zero_a: assert property (
    pready && paddr == CRC_CTRL_OFS |-> prdata[31:30] == 2'h0
    && prdata[26:25] == 2'h0 && prdata[23:13] == 11'h000)
    else $error("Unimplemented CRC control bit read nonzero.");
  no_append_a: assert property (
    s_reg.crc.write_byte_order |-> !s_reg.crc.checksum_append)
    else $error("Append set while write byte order set.");
  ip_poly_a: assert property (
    crc_cfg.checksum_type |-> crc_cfg.poly_length_minus_one == 5'h00)
    else $error("Polynomial length exposed in IP header mode.");
  force_start_a: assert property (
    psel && penable && pready && pwrite && paddr == EVT_CTRL_OFS
    && pwdata[FORCE_BIT] && !pwdata[SWAB_BIT] && s_reg.chan_en
    && !abort_hit && !pattern_match |=> cell_start)
    else $error("Force write did not start a transfer.");

  force_cover_c:   cover property (cell_start ##[1:20] cell_done);
  abort_cover_c:   cover property (channel_busy ##1 xfer_abort);
  pattern_cover_c: cover property (pattern_match ##1 !channel_enable);

endmodule
`default_nettype wire

// ===== tb/dcec_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcec_far_model
  import dcec_pkg::*;
(
  // Clock and reset.
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Channel control seen from the far side.
  input  wire logic         cell_start,
  input  wire logic         xfer_abort,
  // Event sources and source data.
  output var  logic [255:0] irq_lines,
  output var  logic         pattern_match,
  output var  logic         cell_done,
  output var  dcec_word_s   src_word
);
  int unsigned done_delay = 1;
  int unsigned left;

  initial begin
    irq_lines = '0;
    pattern_match = 1'b0;
    src_word = '0;
  end

  // ----------------------------------------------------------------
  // Cell completion, prompt or slow, cancelled by an abort.
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 0;
      cell_done <= 1'b0;
    end else begin
      cell_done <= (left == 1);
      if (xfer_abort === 1'b1) begin
        left <= 0;
      end else if (cell_start === 1'b1) begin
        left <= done_delay;
      end else if (left != 0) begin
        left <= left - 1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event and data tasks.
  // ----------------------------------------------------------------
  task automatic pulse_irq(input int a, input int b);
    @(posedge pclk);
    irq_lines[a] <= 1'b1;
    irq_lines[b] <= 1'b1;
    @(posedge pclk);
    irq_lines <= '0;
  endtask

  task automatic pulse_pat();
    @(posedge pclk);
    pattern_match <= 1'b1;
    @(posedge pclk);
    pattern_match <= 1'b0;
  endtask

  // Aligned words only; data is scrambled once valid drops.
  task automatic send_word(input logic [31:0] d);
    @(posedge pclk);
    src_word <= '{data: d, valid: 1'b1};
    @(posedge pclk);
    src_word <= '{data: ~d, valid: 1'b0};
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_dcec_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dcec_top
  import dcec_pkg::*;
;
  logic          pclk;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [7:0]    paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [255:0]  irq_lines;
  logic          pattern_match;
  logic          cell_done;
  logic          cell_start;
  logic          xfer_abort;
  logic          channel_busy;
  logic          channel_enable;
  logic          irq;
  dcec_crc_cfg_s crc_cfg;
  dcec_word_s    src_word;
  dcec_word_s    crc_word;
  dcec_word_s    dst_word;
  logic [31:0]   rdata;
  logic          rerr;
  logic [31:0]   crc_seen;
  logic [31:0]   dst_seen;
  logic [31:0]   bo_exp [4];
  int            num_errors = 0;
  int            cmp_count = 0;
  int            n_start = 0;
  int            n_abort = 0;
  int            n_crc = 0;
  int            n0;

  dcec_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_lines(irq_lines),
    .pattern_match(pattern_match), .cell_done(cell_done),
    .cell_start(cell_start), .xfer_abort(xfer_abort),
    .channel_busy(channel_busy), .channel_enable(channel_enable),
    .irq(irq), .crc_cfg(crc_cfg), .src_word(src_word),
    .crc_word(crc_word), .dst_word(dst_word)
  );

  dcec_far_model far (
    .pclk(pclk), .presetn(presetn), .cell_start(cell_start),
    .xfer_abort(xfer_abort), .irq_lines(irq_lines),
    .pattern_match(pattern_match), .cell_done(cell_done),
    .src_word(src_word)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Output monitors.
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (cell_start === 1'b1) n_start++;
    if (xfer_abort === 1'b1) n_abort++;
    if (crc_word.valid === 1'b1) begin
      crc_seen = crc_word.data;
      n_crc++;
    end
    if (dst_word.valid === 1'b1) dst_seen = dst_word.data;
  end

  // ----------------------------------------------------------------
  // Bus and check tasks.
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdata);
  endtask

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bo_exp = '{32'h11223344, 32'h44332211, 32'h33441122, 32'h22114433};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd("evt_reset", EVT_CTRL_OFS, 32'h00FFFF00);
    rd("crc_reset", CRC_CTRL_OFS, 32'h00000000);
    wr(CRC_CTRL_OFS, 32'hFFFFFFFF);
    rd("crc_ones", CRC_CTRL_OFS, 32'h39001FA0);
    chk("cfg_ip", 32'h00000F05, 32'(crc_cfg));
    wr(CRC_CTRL_OFS, 32'h01001F40);
    @(posedge pclk);
    chk("cfg_lfsr", 32'h000001FA, 32'(crc_cfg));
    for (int o = 0; o < 4; o++) begin
      wr(CRC_CTRL_OFS, (32'(o) << BYTE_ORDER_LSB) | 32'h08000080);
      far.send_word(32'h11223344);
      repeat (3) @(posedge pclk);
      chk("crc_word", bo_exp[o], crc_seen);
      chk("dst_word", bo_exp[o], dst_seen);
    end
    n0 = n_crc;
    wr(CRC_CTRL_OFS, 32'h10000000);
    far.send_word(32'hA1B2C3D4);
    repeat (3) @(posedge pclk);
    chk("dst_raw", 32'hA1B2C3D4, dst_seen);
    chk("crc_idle", n0, n_crc);
    wr(EVT_CTRL_OFS, 32'h00FFFF80);
    repeat (4) @(posedge pclk);
    chk("start_disabled", 0, n_start);
    wr(CHAN_OFS, 32'h1);
    far.done_delay = 6;
    wr(EVT_CTRL_OFS, 32'h00FFFF80);
    rd("force_reads0", EVT_CTRL_OFS, 32'h00FFFF00);
    chk("force_start", 1, n_start);
    rd("chan_busy", CHAN_OFS, 32'h3);
    repeat (8) @(posedge pclk);
    chk("busy_done", 32'h0, {31'h0, channel_busy});
    far.done_delay = 1;
    wr(EVT_CTRL_OFS, 32'h00FFFF40);
    rd("abort_reads0", EVT_CTRL_OFS, 32'h00FFFF00);
    chk("sw_abort", 1, n_abort);
    far.pulse_pat();
    repeat (4) @(posedge pclk);
    chk("pat_off", 1, n_abort);
    wr(EVT_CTRL_OFS, 32'h00FFFF20);
    far.pulse_pat();
    repeat (4) @(posedge pclk);
    chk("pat_abort", 2, n_abort);
    chk("pat_channel_enable", 32'h0, {31'h0, channel_enable});
    rd("stat_all", INT_STAT_OFS, 32'h7);
    wr(INT_EN_OFS, 32'h0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(INT_STAT_OFS, 32'h0);
    wr(INT_EN_OFS, 32'h2);
    @(posedge pclk);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(INT_CLR_OFS, 32'h2);
    rd("stat_clr", INT_STAT_OFS, 32'h5);
    chk("irq_off", 32'h0, {31'h0, irq});
    wr(INT_CLR_OFS, 32'h5);
    rd("stat_zero", INT_STAT_OFS, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    chk("unmapped_data", 32'h0, rdata);
    wr(CHAN_OFS, 32'h1);
    wr(EVT_CTRL_OFS, 32'h00050300);
    far.pulse_irq(3, 5);
    repeat (4) @(posedge pclk);
    chk("irq_ign_start", 1, n_start);
    chk("irq_ign_abort", 2, n_abort);
    wr(EVT_CTRL_OFS, 32'h00050318);
    far.pulse_irq(3, 3);
    repeat (4) @(posedge pclk);
    chk("irq_start", 2, n_start);
    far.pulse_irq(4, 4);
    repeat (4) @(posedge pclk);
    chk("irq_other", 2, n_start + n_abort - 2);
    far.pulse_irq(5, 5);
    repeat (4) @(posedge pclk);
    chk("irq_abort", 3, n_abort);
    wr(EVT_CTRL_OFS, 32'h00FFFF18);
    far.pulse_irq(255, 255);
    repeat (4) @(posedge pclk);
    chk("tie_start", 2, n_start);
    chk("tie_abort", 4, n_abort);
    complete_run();
  end
endmodule
`default_nettype wire
